//--- rtl/clock_synth_program_ctrl.sv
`timescale 1ns/1ps
// Contract
// - n write copies all three together
// - copy is synchronous, into pointer-selected vco
// - pointer bit 5: 0 video, 1 memory
// - m value bits 6-0, bit 7 stored
// - n value bits 6-0, bit 7 stored
// - bit 0 powers down video vco internally
// - bit 1 powers down memory vco internally
// - bit 2 stops oscillator when permitted and bit 6 high
// - select 0: video vco or reference pin
// - select 1: half memory vco or pin
// - bit 6 low: reference divided by 384
// - bit 6 high: shared pin 32 khz clock
// - bit 7 picks fixed clock defaults
// - pre-scale bit 0: divide 4 or 1
// - post-divide is two to field power
module clock_synth_program_ctrl (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_index,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   output logic [7:0] reg_rd_data,
   input wire logic internal_clock_source_sel,
   input wire logic osc_powerdown_permit,
   input wire logic asymmetric_dram_option,
   input wire logic ref_clk_pin,
   input wire logic mem_clk_pin,
   input wire logic video_clock_vco_out,
   input wire logic mclk_vco_out,
   input wire logic shared_address_pin,
   output logic video_clock_vco_powerdown,
   output logic mclk_vco_powerdown,
   output logic osc_disable,
   output logic video_clock,
   output logic pwrseq_tick,
   output logic dram_option_conflict,
   output logic [15:0] clock0_default_khz,
   output logic [15:0] clock1_default_khz,
   output logic [clk_synth_pkg::NUM_VCO-1:0] vco_ref_div_by1,
   output logic [clk_synth_pkg::NUM_VCO-1:0][2:0] vco_post_div_exp,
   output logic [clk_synth_pkg::NUM_VCO-1:0][6:0] vco_m,
   output logic [clk_synth_pkg::NUM_VCO-1:0][6:0] vco_n
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   localparam logic [8:0] REF_DIV_LAST = 9'(clk_synth_pkg::REF_DIV_COUNT - 1);

   typedef struct packed {
      logic [7:0] prescale; // staging, not yet seen by a vco
      logic [7:0] m; // staging, bit 7 kept as written
      logic [7:0] n; // staging, bit 7 kept as written
      logic [7:0] ctrl; // clock control
      logic load; // transfer strobe, one cycle after the n write
      logic load_ptr; // target vco captured with the strobe
      logic [7:0] rd_data; // registered read answer
      logic [clk_synth_pkg::NUM_SYNC-1:0][2:0] sync; // three-stage pin samplers
      logic [clk_synth_pkg::NUM_SYNC-1:0] stable; // agreed pin levels
      logic [8:0] ref_cnt; // reference edge counter
      logic tick; // sequencing / refresh reference pulse
      logic half_mvco; // memory vco halved
      logic half_mpin; // memory pin halved
      logic video_clock; // selected video clock level
   } ctrl_state_t;

   ctrl_state_t st; // registered copy
   ctrl_state_t next_st; // next value

   logic [clk_synth_pkg::NUM_SYNC-1:0] rise; // rising edges of agreed levels
   logic int_src; // internal source chosen

   assign int_src = internal_clock_source_sel;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      rise = '0;
      next_st.load = 1'b0;
      next_st.tick = 1'b0;

      // register writes; m and n keep all eight bits
      if (reg_wr) begin
         unique case (reg_index)
            clk_synth_pkg::IDX_PRESCALE: next_st.prescale = reg_wdata;
            clk_synth_pkg::IDX_M: next_st.m = reg_wdata;
            clk_synth_pkg::IDX_N: begin
               next_st.n = reg_wdata;
               next_st.load = 1'b1; // fire once the write has landed
            end
            clk_synth_pkg::IDX_CTRL: next_st.ctrl = reg_wdata;
            default: ; // foreign index, ignored
         endcase
      end

      // the pointer at the n write picks the target latch
      if (reg_wr && reg_index == clk_synth_pkg::IDX_N) begin
         next_st.load_ptr = next_st.ctrl[clk_synth_pkg::CTRL_PTR];
      end

      // read answer, one cycle behind the index
      unique case (reg_index)
         clk_synth_pkg::IDX_PRESCALE: next_st.rd_data = st.prescale;
         clk_synth_pkg::IDX_M: next_st.rd_data = st.m;
         clk_synth_pkg::IDX_N: next_st.rd_data = st.n;
         clk_synth_pkg::IDX_CTRL: next_st.rd_data = st.ctrl;
         default: next_st.rd_data = clk_synth_pkg::RD_UNMAPPED;
      endcase

      // pin samplers: stage 0 feeds stage 1 only
      for (int i = 0; i < clk_synth_pkg::NUM_SYNC; i++) begin
         // shift up one stage; stage 0 takes the raw pin just below
         // stage 2 is compared with stage 1 and, when they agree, loaded into stable; never fed back
         next_st.sync[i] = {st.sync[i][1], st.sync[i][0], 1'b0};
         next_st.sync[i][0] = (i == clk_synth_pkg::SIN_REF) ? ref_clk_pin :
                              (i == clk_synth_pkg::SIN_MEM) ? mem_clk_pin :
                              (i == clk_synth_pkg::SIN_VVCO) ? video_clock_vco_out :
                              (i == clk_synth_pkg::SIN_MVCO) ? mclk_vco_out :
                              shared_address_pin;
         if (st.sync[i][1] == st.sync[i][2]) begin
            next_st.stable[i] = st.sync[i][2];
         end
         rise[i] = next_st.stable[i] & ~st.stable[i];
      end

      // sequencing reference: divided reference or shared pin
      if (st.ctrl[clk_synth_pkg::CTRL_PS_REF]) begin
         next_st.ref_cnt = '0;
         next_st.tick = rise[clk_synth_pkg::SIN_SHARED];
      end else if (rise[clk_synth_pkg::SIN_REF]) begin
         if (st.ref_cnt == REF_DIV_LAST) begin
            next_st.ref_cnt = '0;
            next_st.tick = 1'b1;
         end else begin
            next_st.ref_cnt = st.ref_cnt + 9'h001;
         end
      end

      // halving toggles on the rising edges of the memory sources
      if (rise[clk_synth_pkg::SIN_MVCO]) begin
         next_st.half_mvco = ~st.half_mvco;
      end
      if (rise[clk_synth_pkg::SIN_MEM]) begin
         next_st.half_mpin = ~st.half_mpin;
      end

      // video clock source mux
      if (!st.ctrl[clk_synth_pkg::CTRL_VID_SEL]) begin
         next_st.video_clock = int_src ? next_st.stable[clk_synth_pkg::SIN_VVCO]
                                       : next_st.stable[clk_synth_pkg::SIN_REF];
      end else begin
         next_st.video_clock = int_src ? next_st.half_mvco : next_st.half_mpin;
      end
   end

   // ------------------------------------------------------------
   // register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
         st.prescale <= clk_synth_pkg::RST_PRESCALE;
         st.m <= clk_synth_pkg::RST_M;
         st.n <= clk_synth_pkg::RST_N;
         st.ctrl <= clk_synth_pkg::RST_CTRL;
         st.rd_data <= clk_synth_pkg::RD_UNMAPPED;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // vco latches, one per synthesizer
   // ------------------------------------------------------------
   vco_load_if ld_bus [clk_synth_pkg::NUM_VCO] ();

   // only the pointed latch sees the strobe, so the other keeps running
   for (genvar g = 0; g < clk_synth_pkg::NUM_VCO; g++) begin : g_vco
      assign ld_bus[g].load = st.load & (st.load_ptr == 1'(g));
      assign ld_bus[g].prescale = st.prescale;
      assign ld_bus[g].m = st.m;
      assign ld_bus[g].n = st.n;
      vco_latch u_latch (
         .clk (clk),
         .sys_rst (sys_rst),
         .ld (ld_bus[g]),
         .ref_div_by1 (vco_ref_div_by1[g]),
         .post_div_exp (vco_post_div_exp[g]),
         .m_div (vco_m[g]),
         .n_div (vco_n[g])
      );
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign reg_rd_data = st.rd_data;
   // vco power controls only act under the internal source
   assign video_clock_vco_powerdown = st.ctrl[clk_synth_pkg::CTRL_VIDEO_CLOCK_PD] & int_src;
   assign mclk_vco_powerdown = st.ctrl[clk_synth_pkg::CTRL_MCLK_PD] & int_src;
   assign osc_disable = st.ctrl[clk_synth_pkg::CTRL_OSC_PD] & osc_powerdown_permit
                        & st.ctrl[clk_synth_pkg::CTRL_PS_REF];
   assign video_clock = st.video_clock;
   assign pwrseq_tick = st.tick;
   // shared pin cannot carry both the clock and the dram option
   assign dram_option_conflict = st.ctrl[clk_synth_pkg::CTRL_PS_REF]
                                 & asymmetric_dram_option;
   assign clock0_default_khz = st.ctrl[clk_synth_pkg::CTRL_FMODE] ?
                               clk_synth_pkg::FCLK0_MODE1 : clk_synth_pkg::FCLK0_MODE0;
   assign clock1_default_khz = st.ctrl[clk_synth_pkg::CTRL_FMODE] ?
                               clk_synth_pkg::FCLK1_MODE1 : clk_synth_pkg::FCLK1_MODE0;

endmodule // clock_synth_program_ctrl

//--- rtl/clk_synth_pkg.sv
package clk_synth_pkg;

   // ------------------------------------------------------------
   // register indices at the indexed i/o port
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_PRESCALE = 8'h30; // pre-scale / post-divide
   localparam logic [7:0] IDX_M = 8'h31; // m-divisor
   localparam logic [7:0] IDX_N = 8'h32; // n-divisor, triggers the load
   localparam logic [7:0] IDX_CTRL = 8'h33; // clock control

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_PRESCALE = 8'h00;
   localparam logic [7:0] RST_M = 8'h00;
   localparam logic [7:0] RST_N = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00; // every control default is 0
   localparam logic [7:0] RD_UNMAPPED = 8'h00; // answer to foreign indices

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int PRE_REF_SEL = 0; // 0: ref / 4, 1: ref / 1
   localparam int PRE_POST_LSB = 1; // post-divide exponent
   localparam int PRE_POST_MSB = 3;
   localparam int DIV_MSB = 6; // m and n values sit in 6..0
   localparam int CTRL_VIDEO_CLOCK_PD = 0;
   localparam int CTRL_MCLK_PD = 1;
   localparam int CTRL_OSC_PD = 2;
   localparam int CTRL_VID_SEL = 4;
   localparam int CTRL_PTR = 5;
   localparam int CTRL_PS_REF = 6;
   localparam int CTRL_FMODE = 7;

   // ------------------------------------------------------------
   // vco selection and timing
   // ------------------------------------------------------------
   localparam int NUM_VCO = 2;
   localparam logic PTR_VIDEO = 1'b0; // video-clock vco
   localparam logic PTR_MEM = 1'b1; // memory-clock vco
   localparam int REF_DIV_COUNT = 384; // reference edges per sequencing tick

   // ------------------------------------------------------------
   // synchronised pin inputs
   // ------------------------------------------------------------
   localparam int SIN_REF = 0;
   localparam int SIN_MEM = 1;
   localparam int SIN_VVCO = 2;
   localparam int SIN_MVCO = 3;
   localparam int SIN_SHARED = 4;
   localparam int NUM_SYNC = 5;

   // ------------------------------------------------------------
   // fixed clock defaults in khz
   // ------------------------------------------------------------
   localparam logic [15:0] FCLK0_MODE0 = 16'h6257; // 25175 khz
   localparam logic [15:0] FCLK1_MODE0 = 16'h6ea2; // 28322 khz
   localparam logic [15:0] FCLK0_MODE1 = 16'h7b0c; // 31500 khz
   localparam logic [15:0] FCLK1_MODE1 = 16'h8aac; // 35500 khz

endpackage

//--- rtl/vco_load_if.sv
`timescale 1ns/1ps
// one load channel from the register side to a vco counter latch
interface vco_load_if;
   logic load; // one-cycle transfer strobe
   logic [7:0] prescale; // pre-scale / post-divide image
   logic [7:0] m; // m-divisor image
   logic [7:0] n; // n-divisor image
   modport ctrl (output load, output prescale, output m, output n);
   modport latch (input load, input prescale, input m, input n);
endinterface

//--- rtl/vco_latch.sv
`timescale 1ns/1ps
module vco_latch (
   input wire logic clk,
   input wire logic sys_rst,
   vco_load_if.latch ld,
   output logic ref_div_by1,
   output logic [2:0] post_div_exp,
   output logic [6:0] m_div,
   output logic [6:0] n_div
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic ref_div_by1; // pre-scale choice
      logic [2:0] post_div_exp; // divide by two to this power
      logic [6:0] m_div;
      logic [6:0] n_div;
   } latch_state_t;

   latch_state_t st; // registered copy
   latch_state_t next_st; // next value

   // ------------------------------------------------------------
   // next state: all fields move on the one strobe
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (ld.load) begin
         next_st.ref_div_by1 = ld.prescale[clk_synth_pkg::PRE_REF_SEL];
         next_st.post_div_exp =
            ld.prescale[clk_synth_pkg::PRE_POST_MSB:clk_synth_pkg::PRE_POST_LSB];
         next_st.m_div = ld.m[clk_synth_pkg::DIV_MSB:0];
         next_st.n_div = ld.n[clk_synth_pkg::DIV_MSB:0];
      end
   end

   // register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ref_div_by1 = st.ref_div_by1;
   assign post_div_exp = st.post_div_exp;
   assign m_div = st.m_div;
   assign n_div = st.n_div;

endmodule // vco_latch

//--- sim/clock_synth_program_ctrl_props.sv
`timescale 1ns/1ps
module clock_synth_program_ctrl_props (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_index,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [7:0] reg_rd_data,
   input wire logic internal_clock_source_sel,
   input wire logic osc_powerdown_permit,
   input wire logic asymmetric_dram_option,
   input wire logic video_clock_vco_powerdown,
   input wire logic mclk_vco_powerdown,
   input wire logic osc_disable,
   input wire logic dram_option_conflict,
   input wire logic [15:0] clock0_default_khz,
   input wire logic [15:0] clock1_default_khz,
   input wire logic [1:0] vco_ref_div_by1,
   input wire logic [1:0][2:0] vco_post_div_exp,
   input wire logic [1:0][6:0] vco_m,
   input wire logic [1:0][6:0] vco_n
);
   // ------------------------------------------------------------
   // shadow of the four registers, rebuilt from the write strobes
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0][7:0] regs; // prescale, m, n, control
   } shadow_t;
   shadow_t st;
   shadow_t next_st;
   logic mapped; // index inside the register block
   logic nwr; // n write, the load trigger
   logic [7:0] ctrl;
   logic [7:0] rd_exp; // what the read port must show next cycle
   logic [10:0] lat_v; // prescale and m fields that a load copies
   assign mapped = reg_index[7:2] == 6'h0c;
   assign nwr = reg_wr && reg_index == clk_synth_pkg::IDX_N;
   assign ctrl = st.regs[3];
   assign rd_exp = mapped ? st.regs[reg_index[1:0]] : clk_synth_pkg::RD_UNMAPPED;
   assign lat_v = {st.regs[0][0], st.regs[0][3:1], st.regs[1][6:0]};
   // next shadow: foreign indices write nothing
   always_comb begin
      next_st = st;
      if (reg_wr && mapped) begin
         next_st.regs[reg_index[1:0]] = reg_wdata;
      end
   end
   // shadow register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // pointer decides the target, seen at the n write edge
   sequence s_nwr_vid; nwr && !ctrl[5]; endsequence
   sequence s_nwr_mem; nwr && ctrl[5]; endsequence
   property p_load_vid;
      s_nwr_vid |-> ##2 ({vco_ref_div_by1[0], vco_post_div_exp[0], vco_m[0]} == $past(lat_v, 2)
         && vco_n[0] == $past(reg_wdata[6:0], 2) && $stable({vco_m[1], vco_n[1]}));
   endproperty
   a_load_vid: assert property (p_load_vid) else $error("video vco load wrong");
   property p_load_mem;
      s_nwr_mem |-> ##2 ({vco_ref_div_by1[1], vco_post_div_exp[1], vco_m[1]} == $past(lat_v, 2)
         && vco_n[1] == $past(reg_wdata[6:0], 2) && $stable({vco_m[0], vco_n[0]}));
   endproperty
   a_load_mem: assert property (p_load_mem) else $error("memory vco load wrong");
   property p_hold;
      !$past(nwr, 2) |-> $stable({vco_ref_div_by1, vco_post_div_exp, vco_m, vco_n});
   endproperty
   a_hold: assert property (p_hold) else $error("vco changed without n write");
   property p_rd; reg_rd_data == $past(rd_exp); endproperty
   a_rd: assert property (p_rd) else $error("read data wrong");
   property p_vpd; video_clock_vco_powerdown == (ctrl[0] && internal_clock_source_sel); endproperty
   a_vpd: assert property (p_vpd) else $error("video vco powerdown wrong");
   property p_mpd; mclk_vco_powerdown == (ctrl[1] && internal_clock_source_sel); endproperty
   a_mpd: assert property (p_mpd) else $error("memory vco powerdown wrong");
   property p_osc; osc_disable == (ctrl[2] && ctrl[6] && osc_powerdown_permit); endproperty
   a_osc: assert property (p_osc) else $error("oscillator disable wrong");
   property p_conf; dram_option_conflict == (ctrl[6] && asymmetric_dram_option); endproperty
   a_conf: assert property (p_conf) else $error("dram conflict flag wrong");
   property p_fdef;
      clock0_default_khz == (ctrl[7] ? clk_synth_pkg::FCLK0_MODE1 : clk_synth_pkg::FCLK0_MODE0)
         && clock1_default_khz ==
            (ctrl[7] ? clk_synth_pkg::FCLK1_MODE1 : clk_synth_pkg::FCLK1_MODE0);
   endproperty
   a_fdef: assert property (p_fdef) else $error("fixed clock defaults wrong");
endmodule // clock_synth_program_ctrl_props
bind clock_synth_program_ctrl clock_synth_program_ctrl_props props (.*);

//--- sim/clock_synth_program_ctrl_test.sv
`timescale 1ns/1ps
module clock_synth_program_ctrl_test;
   // ------------------------------------------------------------
   // bench signals, named as the ports so that .* connects them
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_index = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic internal_clock_source_sel = 1'b0, osc_powerdown_permit = 1'b0;
   logic asymmetric_dram_option = 1'b0;
   logic [4:0] pins = 5'h00; // slow pin levels, by sampler slot
   wire logic ref_clk_pin = pins[clk_synth_pkg::SIN_REF];
   wire logic mem_clk_pin = pins[clk_synth_pkg::SIN_MEM];
   wire logic video_clock_vco_out = pins[clk_synth_pkg::SIN_VVCO];
   wire logic mclk_vco_out = pins[clk_synth_pkg::SIN_MVCO];
   wire logic shared_address_pin = pins[clk_synth_pkg::SIN_SHARED];
   logic [7:0] reg_rd_data;
   logic video_clock_vco_powerdown, mclk_vco_powerdown, osc_disable, video_clock, pwrseq_tick;
   logic dram_option_conflict;
   logic [15:0] clock0_default_khz, clock1_default_khz;
   logic [1:0] vco_ref_div_by1;
   logic [1:0][2:0] vco_post_div_exp;
   logic [1:0][6:0] vco_m, vco_n;
   int miscompares = 0;
   int compares = 0;
   int vid_edges = 0; // rising edges of the video clock
   int ticks = 0; // sequencing pulses seen
   clock_synth_program_ctrl DUT (.*);
   always #2.5 clk = ~clk;
   always @(posedge video_clock) vid_edges++;
   always @(posedge pwrseq_tick) ticks++;
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // strobe stays up so that writes can run back to back
   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      @(posedge clk);
      reg_index <= idx;
      reg_wdata <= data;
      reg_wr <= 1'b1;
   endtask
   task automatic idle(input int n);
      @(posedge clk);
      reg_wr <= 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      @(posedge clk);
      reg_index <= idx;
      reg_wr <= 1'b0;
      @(posedge clk);
      #1;
      chk("read data", 32'(exp), 32'(reg_rd_data));
   endtask
   // phases of four cycles each, well above the sampler minimum
   task automatic pulse(input int pin, input int n);
      repeat (n) begin
         @(posedge clk);
         pins[pin] <= 1'b1;
         repeat (4) @(posedge clk);
         pins[pin] <= 1'b0;
         repeat (3) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask
   function automatic logic [31:0] img(input int i);
      return 32'({vco_ref_div_by1[i], vco_post_div_exp[i], vco_m[i], vco_n[i]});
   endfunction
   task automatic t_regs();
      logic [7:0] v[4] = '{8'h8d, 8'hc5, 8'hb3, 8'h88};
      for (int i = 0; i < 4; i++) rd_chk(8'h30 + 8'(i), 8'h00);
      for (int i = 0; i < 4; i++) wr(8'h30 + 8'(i), v[i]);
      wr(8'h34, 8'hff);
      wr(8'h2f, 8'hff);
      for (int i = 0; i < 4; i++) rd_chk(8'h30 + 8'(i), v[i]);
      rd_chk(8'h34, 8'h00);
   endtask
   task automatic t_load();
      wr(clk_synth_pkg::IDX_CTRL, 8'h20);
      wr(clk_synth_pkg::IDX_PRESCALE, 8'h0e);
      wr(clk_synth_pkg::IDX_M, 8'h7f);
      idle(4);
      chk("video vco", 32'({1'b1, 3'h6, 7'h45, 7'h33}), img(0));
      chk("memory vco", 32'h0000_0000, img(1));
      wr(clk_synth_pkg::IDX_N, 8'h81);
      idle(3);
      chk("memory vco", 32'({1'b0, 3'h7, 7'h7f, 7'h01}), img(1));
      chk("video vco", 32'({1'b1, 3'h6, 7'h45, 7'h33}), img(0));
      wr(clk_synth_pkg::IDX_CTRL, 8'h00);
      wr(clk_synth_pkg::IDX_N, 8'h40);
      idle(3);
      chk("video vco", 32'({1'b0, 3'h7, 7'h7f, 7'h40}), img(0));
      chk("memory vco", 32'({1'b0, 3'h7, 7'h7f, 7'h01}), img(1));
   endtask
   task automatic t_ctrl();
      wr(clk_synth_pkg::IDX_CTRL, 8'hc7);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         reg_wr <= 1'b0;
         {asymmetric_dram_option, osc_powerdown_permit, internal_clock_source_sel} <= i[2:0];
         repeat (2) @(posedge clk);
         #1;
         chk("powerdowns", 32'({2{i[0]}}), 32'({video_clock_vco_powerdown, mclk_vco_powerdown}));
         chk("oscillator disable", 32'(i[1]), 32'(osc_disable));
         chk("dram conflict", 32'(i[2]), 32'(dram_option_conflict));
         chk("clock0", 32'(clk_synth_pkg::FCLK0_MODE1), 32'(clock0_default_khz));
      end
      wr(clk_synth_pkg::IDX_CTRL, 8'h07);
      idle(2);
      chk("oscillator disable", 32'h0000_0000, 32'(osc_disable));
      chk("clock1 default", 32'(clk_synth_pkg::FCLK1_MODE0), 32'(clock1_default_khz));
   endtask
   task automatic t_video();
      logic [7:0] ctl[6] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h10, 8'h10};
      logic sel[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      int pin[6] = '{0, 2, 0, 3, 1, 3};
      int exp[6] = '{4, 4, 0, 2, 2, 0};
      int t0;
      for (int i = 0; i < 6; i++) begin
         wr(clk_synth_pkg::IDX_CTRL, ctl[i]);
         internal_clock_source_sel <= sel[i];
         idle(8);
         t0 = vid_edges;
         pulse(pin[i], 4);
         chk("video clock edges", 32'(exp[i]), 32'(vid_edges - t0));
      end
   endtask
   task automatic t_pwrseq();
      int t0;
      pulse(clk_synth_pkg::SIN_REF, 383);
      chk("ticks at 383", 32'h0000_0000, 32'(ticks));
      pulse(clk_synth_pkg::SIN_REF, 1);
      chk("ticks at 384", 32'h0000_0001, 32'(ticks));
      wr(clk_synth_pkg::IDX_CTRL, 8'h40);
      idle(4);
      t0 = ticks;
      pulse(clk_synth_pkg::SIN_SHARED, 3);
      pulse(clk_synth_pkg::SIN_REF, 2);
      chk("shared pin ticks", 32'h0000_0003, 32'(ticks - t0));
   endtask
   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // hang guard: the sequence needs well under 20000 cycles
   initial begin
      #200000;
      miscompares++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      t_pwrseq();
      wr(clk_synth_pkg::IDX_CTRL, 8'h00);
      t_regs();
      t_load();
      t_ctrl();
      t_video();
      close_out();
   end
endmodule // clock_synth_program_ctrl_test
